//--- design/otpc_ctrl.sv
// host-side controller for an 8k x 8 one-time-programmable rom
// assumes one rom per select line; user issues one command at a time
`timescale 1ns/10ps
`include "otpc_defines.svh"
module otpc_ctrl
	import otpc_pkg::*;
#(
	parameter int ACCESS_NS = `OTPC_ACCESS_NS,
	parameter int GATE_NS = `OTPC_GATE_TO_OUT_NS,
	parameter int FLOAT_NS = `OTPC_FLOAT_NS,
	parameter int PULSE_CYC = `OTPC_CYC_UP(`OTPC_PULSE_NS),
	parameter int SETUP_CYC = `OTPC_CYC_UP(`OTPC_SETUP_NS),
	parameter int MAX_PULSES = `OTPC_MAX_PULSES
)
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire otpc_op_type cmd_op,
	input wire logic [`OTPC_ADDR_W-1:0] cmd_addr,
	input wire logic [`OTPC_DATA_W-1:0] cmd_wdata,
	output logic rsp_valid,
	output logic [`OTPC_DATA_W-1:0] rsp_rdata,
	output otpc_res_type rsp_result,
	output logic [4:0] rsp_pulses,
	output logic rom_select_n,
	output logic rom_gate_n,
	output logic rom_program_pulse_n,
	output logic rom_vpp_high,
	output logic rom_vcc_high,
	output logic rom_signature_high_voltage_line,
	output logic [`OTPC_ADDR_W-1:0] rom_addr,
	output logic [`OTPC_DATA_W-1:0] rom_data_out,
	output logic rom_data_oe,
	input wire logic [`OTPC_DATA_W-1:0] rom_data_in
);
	// gate lag after select, and wait from gate to sample (plus 2 sync + 1 pin flop)
	localparam int GATE_LAG = (ACCESS_NS - GATE_NS) / `OTPC_CLK_PERIOD_NS;
	localparam int GATE_WAIT = `OTPC_CYC_UP(GATE_NS) + 3;
	localparam int FLOAT_CYC = `OTPC_CYC_UP(FLOAT_NS) + 1;
	localparam int CW = 32;

	initial
	begin
		if (ACCESS_NS < GATE_NS || MAX_PULSES < 1 || MAX_PULSES > 31 || PULSE_CYC < 1)
			$error("otpc_ctrl: unsupported parameters");
		if (SETUP_CYC < 1 || FLOAT_NS < 0)
			$error("otpc_ctrl: unsupported timing parameters");
	end

	typedef enum logic [3:0]
	{
		st_idle, st_setup, st_select, st_gate, st_sample, st_float,
		st_pulse, st_vgate, st_vsample, st_over, st_done
	} otpc_state_type;

	otpc_pins_if pins_if();

	otpc_state_type state_q, state_d;
	otpc_op_type op_q, op_d;
	logic [`OTPC_ADDR_W-1:0] addr_q, addr_d;
	logic [`OTPC_DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic [4:0] pulses_q, pulses_d;
	otpc_res_type res_q, res_d;
	logic ok_q, ok_d;

	// *************************************************************
	// helpers
	// *************************************************************
	function automatic logic [CW-1:0] cyc(input int n);
		cyc = (n < 1) ? CW'(1) : CW'(n);
	endfunction : cyc

	function automatic logic prog_mode(input otpc_op_type op);
		prog_mode = (op == otpc_op_program);
	endfunction : prog_mode

	function automatic logic [CW-1:0] over_len(input logic [4:0] x);
		over_len = CW'(`OTPC_OVER_MULT * PULSE_CYC) * CW'(x);
	endfunction : over_len

	// *************************************************************
	// sequencer
	// *************************************************************
	always_comb
	begin
		state_d = state_q;
		op_d = op_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		cnt_d = (cnt_q != '0) ? cnt_q - CW'(1) : cnt_q;
		pulses_d = pulses_q;
		res_d = res_q;
		ok_d = ok_q;
		case (state_q)
			st_idle:
			begin
				// standby is no command: select simply stays high
				if (cmd_valid && cmd_op != otpc_op_standby)
				begin
					op_d = cmd_op;
					addr_d = cmd_addr;
					if (cmd_op == otpc_op_signature)
						addr_d = cmd_addr[0] ? `OTPC_SIG_DEV_ADDR : `OTPC_SIG_MFR_ADDR;
					wdata_d = cmd_wdata;
					pulses_d = '0;
					res_d = otpc_res_ok;
					ok_d = 1'b0;
					cnt_d = cyc(SETUP_CYC);
					state_d = st_setup;
				end
			end
			st_setup:
				if (cnt_q == '0)
				begin
					cnt_d = prog_mode(op_q) ? cyc(PULSE_CYC) : cyc(GATE_LAG);
					state_d = prog_mode(op_q) ? st_pulse : st_select;
				end
			st_select:
				if (cnt_q == '0)
				begin
					cnt_d = cyc(GATE_WAIT);
					state_d = st_gate;
				end
			st_gate:
				if (cnt_q == '0)
					state_d = st_sample;
			st_sample:
			begin
				rdata_d = pins_if.rdata;
				if (op_q == otpc_op_verify_cold && pins_if.rdata != wdata_q)
					res_d = otpc_res_verify_fail;
				cnt_d = cyc(FLOAT_CYC);
				state_d = st_float;
			end
			st_pulse:
				if (cnt_q == '0)
				begin
					// every initial pulse is followed by a verify read
					pulses_d = pulses_q + 5'd1;
					cnt_d = cyc(GATE_WAIT + GATE_LAG);
					state_d = st_vgate;
				end
			st_vgate:
				if (cnt_q == '0)
					state_d = st_vsample;
			st_vsample:
			begin
				rdata_d = pins_if.rdata;
				if (ok_q)
				begin
					cnt_d = cyc(FLOAT_CYC);
					state_d = st_float;
				end
				else if (pins_if.rdata == wdata_q)
				begin
					ok_d = 1'b1;
					// float time first, then the 3X overprogram pulse
					cnt_d = cyc(FLOAT_CYC) + over_len(pulses_q);
					state_d = st_over;
				end
				else if (pulses_q >= 5'(MAX_PULSES))
				begin
					res_d = otpc_res_program_fail;
					cnt_d = cyc(FLOAT_CYC);
					state_d = st_float;
				end
				else
				begin
					// the leading float counts let the rom release the bus
					cnt_d = cyc(FLOAT_CYC + PULSE_CYC);
					state_d = st_pulse;
				end
			end
			st_over:
				if (cnt_q == '0)
				begin
					cnt_d = cyc(GATE_WAIT + GATE_LAG);
					state_d = st_vgate;
				end
			st_float:
				if (cnt_q == '0)
					state_d = st_done;
			st_done:
				state_d = st_idle;
			default:
				state_d = st_idle;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= st_idle;
			op_q <= otpc_op_read;
			addr_q <= '0;
			wdata_q <= '0;
			rdata_q <= '0;
			cnt_q <= '0;
			pulses_q <= '0;
			res_q <= otpc_res_ok;
			ok_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			op_q <= op_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
			cnt_q <= cnt_d;
			pulses_q <= pulses_d;
			res_q <= res_d;
			ok_q <= ok_d;
		end
	end

	// *************************************************************
	// pin levels per state
	// *************************************************************
	logic pulse_phase;
	logic busy;

	always_comb
	begin
		busy = (state_q != st_idle) && (state_q != st_done);
		// pulses start only after the leading float counts of their state
		pulse_phase = (state_q == st_pulse && cnt_q > cyc(1) && cnt_q <= cyc(PULSE_CYC))
			|| (state_q == st_over && cnt_q != '0 && cnt_q <= over_len(pulses_q));
		// select low only while busy; high otherwise keeps rom in standby/inhibit
		pins_if.select_n = !busy || (state_q == st_setup);
		if (state_q == st_pulse && !pulse_phase)
			pins_if.select_n = 1'b0;
		pins_if.gate_n = !(state_q == st_gate || state_q == st_sample
			|| state_q == st_vgate || state_q == st_vsample);
		pins_if.program_pulse_n = !pulse_phase;
		pins_if.vpp_high = busy && prog_mode(op_q);
		pins_if.vcc_high = busy && prog_mode(op_q);
		pins_if.signature_high_voltage_line = busy && (op_q == otpc_op_signature);
		pins_if.addr = addr_q;
		// host drives data only after gate has been high for the float time,
		// so the bus never fights the rom
		pins_if.drive = busy && prog_mode(op_q) && (state_q == st_setup
			|| (state_q == st_pulse && cnt_q <= cyc(PULSE_CYC))
			|| (state_q == st_over && cnt_q <= over_len(pulses_q)));
		pins_if.wdata = wdata_q;
	end

	// *************************************************************
	// registered pin stage
	// *************************************************************
	otpc_pin_stage u_pins
	(
		.ref_clk(ref_clk),
		.rstn(rstn),
		.p(pins_if.pins),
		.rom_select_n(rom_select_n),
		.rom_gate_n(rom_gate_n),
		.rom_program_pulse_n(rom_program_pulse_n),
		.rom_vpp_high(rom_vpp_high),
		.rom_vcc_high(rom_vcc_high),
		.rom_signature_high_voltage_line(rom_signature_high_voltage_line),
		.rom_addr(rom_addr),
		.rom_data_out(rom_data_out),
		.rom_data_oe(rom_data_oe),
		.rom_data_in(rom_data_in)
	);

	// *************************************************************
	// command and response
	// *************************************************************
	assign cmd_ready = (state_q == st_idle);
	assign rsp_valid = (state_q == st_done);
	assign rsp_rdata = rdata_q;
	assign rsp_result = res_q;
	assign rsp_pulses = pulses_q;
endmodule : otpc_ctrl

//--- design/otpc_defines.svh
// timing and geometry constants for the one-time-programmable rom controller
// assumes a 250 MHz ref_clk; every cycle count is derived from a time in ns
`ifndef OTPC_DEFINES_SVH
`define OTPC_DEFINES_SVH
`define OTPC_CLK_PERIOD_NS 4
`define OTPC_ADDR_W 13
`define OTPC_DATA_W 8
`define OTPC_ACCESS_NS 200
`define OTPC_GATE_TO_OUT_NS 75
`define OTPC_FLOAT_NS 55
`define OTPC_PULSE_NS 1000000
`define OTPC_OVER_MULT 3
`define OTPC_MAX_PULSES 25
`define OTPC_SETUP_NS 2000
`define OTPC_CYC_UP(ns) (((ns) + `OTPC_CLK_PERIOD_NS - 1) / `OTPC_CLK_PERIOD_NS)
`define OTPC_SIG_ADDR_LINE 9
`define OTPC_SIG_MFR_ADDR 13'h0000
`define OTPC_SIG_DEV_ADDR 13'h0001
`define OTPC_ERASED_BYTE 8'hFF
`endif

//--- design/otpc_pkg.sv
// types shared by the rom controller and its pin driver
// assumes otpc_defines.svh for widths
package otpc_pkg;
	typedef enum logic [2:0]
	{
		otpc_op_read,
		otpc_op_program,
		otpc_op_signature,
		otpc_op_verify_cold,
		otpc_op_standby
	} otpc_op_type;

	typedef enum logic [1:0]
	{
		otpc_res_ok,
		otpc_res_verify_fail,
		otpc_res_program_fail
	} otpc_res_type;
endpackage : otpc_pkg

//--- design/otpc_pins_if.sv
// bundle of the rom pin-level signals between the sequencer and the pin stage
// assumes one ref_clk domain
`timescale 1ns/10ps
`include "otpc_defines.svh"
interface otpc_pins_if;
	logic select_n;
	logic gate_n;
	logic program_pulse_n;
	logic vpp_high;
	logic vcc_high;
	logic signature_high_voltage_line;
	logic [`OTPC_ADDR_W-1:0] addr;
	logic [`OTPC_DATA_W-1:0] wdata;
	logic drive;
	logic [`OTPC_DATA_W-1:0] rdata;
	modport seq
	(
		output select_n, gate_n, program_pulse_n, vpp_high, vcc_high,
		output signature_high_voltage_line, addr, wdata, drive,
		input rdata
	);
	modport pins
	(
		input select_n, gate_n, program_pulse_n, vpp_high, vcc_high,
		input signature_high_voltage_line, addr, wdata, drive,
		output rdata
	);
endinterface : otpc_pins_if

//--- design/otpc_pin_stage.sv
// registered pin stage: drives rom pins from flops, syncs data inputs twice
// assumes the rom data bus is external and asynchronous to ref_clk
`timescale 1ns/10ps
`include "otpc_defines.svh"
module otpc_pin_stage
	import otpc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	otpc_pins_if.pins p,
	output logic rom_select_n,
	output logic rom_gate_n,
	output logic rom_program_pulse_n,
	output logic rom_vpp_high,
	output logic rom_vcc_high,
	output logic rom_signature_high_voltage_line,
	output logic [`OTPC_ADDR_W-1:0] rom_addr,
	output logic [`OTPC_DATA_W-1:0] rom_data_out,
	output logic rom_data_oe,
	input wire logic [`OTPC_DATA_W-1:0] rom_data_in
);
	logic [`OTPC_DATA_W-1:0] sync1_q, sync1_d, sync2_q, sync2_d;

	always_comb
	begin
		sync1_d = rom_data_in;
		sync2_d = sync1_q;
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rom_select_n <= 1'b1;
			rom_gate_n <= 1'b1;
			rom_program_pulse_n <= 1'b1;
			rom_vpp_high <= 1'b0;
			rom_vcc_high <= 1'b0;
			rom_signature_high_voltage_line <= 1'b0;
			rom_addr <= '0;
			rom_data_out <= '0;
			rom_data_oe <= 1'b0;
			sync1_q <= '0;
			sync2_q <= '0;
		end
		else
		begin
			rom_select_n <= p.select_n;
			rom_gate_n <= p.gate_n;
			rom_program_pulse_n <= p.program_pulse_n;
			rom_vpp_high <= p.vpp_high;
			rom_vcc_high <= p.vcc_high;
			rom_signature_high_voltage_line <= p.signature_high_voltage_line;
			rom_addr <= p.addr;
			rom_data_out <= p.wdata;
			rom_data_oe <= p.drive;
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
		end
	end

	assign p.rdata = sync2_q;
endmodule : otpc_pin_stage

//--- tb/otpc_rom_model.sv
// behavioural model of the one-time-programmable rom at the controller pins
// assumes zero pin delay; the controller spaces its own edges
`timescale 1ns/10ps
module otpc_rom_model
#(
	parameter logic [7:0] MFR_CODE = 8'h5A, // arbitrary
	parameter logic [7:0] DEV_CODE = 8'hC3, // arbitrary
	parameter int NEED = 2,
	parameter logic [12:0] STUCK = 13'h1ABC
)
(
	input wire logic select_n,
	input wire logic gate_n,
	input wire logic program_pulse_n,
	input wire logic vpp_high,
	input wire logic signature_high_voltage_line,
	input wire logic [12:0] addr,
	input wire logic [7:0] din,
	input wire logic host_oe,
	output logic [7:0] dout
);
	logic [7:0] mem [8192];
	logic [7:0] val;
	logic [7:0] last;
	logic drv;
	int cnt;
	initial
	begin
		foreach (mem[i]) mem[i] = 8'hFF;
		last = 8'h00;
		cnt = 0;
	end
	// a byte takes only after NEED pulses; STUCK never takes
	// a pulse counts at its rising end, when select and supply have long settled
	always @(posedge program_pulse_n)
		if (vpp_high && !select_n)
		begin
			cnt++;
			if (cnt >= NEED && addr != STUCK)
				mem[addr] = mem[addr] & din;
		end
	always @(addr or negedge vpp_high) cnt = 0;
	assign drv = !select_n && !gate_n && program_pulse_n && !host_oe;
	assign val = signature_high_voltage_line ? (addr[0] ? DEV_CODE : MFR_CODE) : mem[addr];
	always @* if (drv) last = val;
	// released bus shows the inverse of the last byte
	assign dout = drv ? val : ~last;
endmodule : otpc_rom_model

//--- tb/otpc_ctrl_properties.sv
// pin-sequence checks for the rom controller
// assumes binding to otpc_ctrl, single ref_clk domain
`timescale 1ns/10ps
`include "otpc_defines.svh"
module otpc_ctrl_chk
	import otpc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire otpc_op_type cmd_op,
	input wire logic [12:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_rdata,
	input wire otpc_res_type rsp_result,
	input wire logic [4:0] rsp_pulses,
	input wire logic rom_select_n,
	input wire logic rom_gate_n,
	input wire logic rom_program_pulse_n,
	input wire logic rom_vpp_high,
	input wire logic rom_vcc_high,
	input wire logic rom_signature_high_voltage_line,
	input wire logic [12:0] rom_addr,
	input wire logic [7:0] rom_data_out,
	input wire logic rom_data_oe,
	input wire logic [7:0] rom_data_in
);
	logic [5:0] sel_cnt_q;
	logic [5:0] sel_cnt_d;
	always_comb sel_cnt_d = rom_select_n ? 6'h00 : sel_cnt_q + {5'h00, sel_cnt_q != 6'h3F};
	always_ff @(posedge ref_clk or negedge rstn)
		if (!rstn)
			sel_cnt_q <= 6'h00;
		else
			sel_cnt_q <= sel_cnt_d;
	// cycles since gate went high, saturating
	logic [5:0] gate_hi_q;
	logic [5:0] gate_hi_d;
	always_comb gate_hi_d = rom_gate_n ? gate_hi_q + {5'h00, gate_hi_q != 6'h3F} : 6'h00;
	always_ff @(posedge ref_clk or negedge rstn)
		if (!rstn)
			gate_hi_q <= 6'h3F;
		else
			gate_hi_q <= gate_hi_d;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	a_gate_needs_sel: assert property (!rom_gate_n |-> !rom_select_n)
		else $error("gate low while deselected");
	a_pulse_in_prog: assert property (!rom_program_pulse_n |-> rom_vpp_high && !rom_select_n)
		else $error("pulse outside program mode");
	a_vcc_with_vpp: assert property (rom_vpp_high |-> rom_vcc_high)
		else $error("vpp without raised core supply");
	a_no_contention: assert property (rom_data_oe |-> rom_gate_n && gate_hi_q >= 6'd14)
		else $error("host drives while rom outputs");
	a_sig_addr_low: assert property (rom_signature_high_voltage_line |-> rom_addr[12:1] == 12'h000 && !rom_vpp_high)
		else $error("signature mode with bad address");
	a_pulse_cap: assert property (rsp_valid |-> rsp_pulses <= 5'd25)
		else $error("too many initial pulses");
	a_gate_lag: assert property ($fell(rom_gate_n) && !rom_vpp_high |-> sel_cnt_q >= 6'd31)
		else $error("gate fell too soon after select");
	a_busy_after_take: assert property (cmd_valid && cmd_ready && cmd_op != otpc_op_standby |=> !cmd_ready [*2])
		else $error("ready while busy");
	a_standby_idle: assert property (cmd_ready && !cmd_valid |-> rom_select_n)
		else $error("idle controller selects rom");
	c_prog_fail: cover property (rsp_valid && rsp_result == otpc_res_program_fail);
	c_ver_fail: cover property (rsp_valid && rsp_result == otpc_res_verify_fail);
	c_sig: cover property (rom_signature_high_voltage_line && !rom_gate_n);
endmodule : otpc_ctrl_chk
bind otpc_ctrl otpc_ctrl_chk chk (.*);

//--- tb/tb_top.sv
// self-checking bench for the rom controller against the rom model
// assumes short pulse and setup counts set by parameter
`timescale 1ns/10ps
module tb_top;
	import otpc_pkg::*;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic cmd_valid = 1'b0;
	otpc_op_type cmd_op = otpc_op_read;
	logic [12:0] cmd_addr = 13'h0000;
	logic [7:0] cmd_wdata = 8'h00;
	logic cmd_ready, rsp_valid, sel_n, gate_n, pls_n, vpp, sig, oe;
	logic [12:0] addr;
	logic [7:0] rdata, dout, din, d;
	otpc_res_type result;
	logic [4:0] pulses;
	logic [15:0] exp_q[$];
	logic [15:0] e;
	int error_cnt = 0;
	int tests_run = 0;
	int seed = 58;
	`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
		$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
	always #2 ref_clk = ~ref_clk;
	otpc_ctrl #(.PULSE_CYC(20), .SETUP_CYC(4)) uut (.ref_clk(ref_clk), .rstn(rstn),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rdata), .rsp_result(result),
		.rsp_pulses(pulses), .rom_select_n(sel_n), .rom_gate_n(gate_n),
		.rom_program_pulse_n(pls_n), .rom_vpp_high(vpp), .rom_vcc_high(),
		.rom_signature_high_voltage_line(sig), .rom_addr(addr), .rom_data_out(dout),
		.rom_data_oe(oe), .rom_data_in(din));
	otpc_rom_model rom (.select_n(sel_n), .gate_n(gate_n), .program_pulse_n(pls_n),
		.vpp_high(vpp), .signature_high_voltage_line(sig), .addr(addr), .din(dout),
		.host_oe(oe), .dout(din));
	task automatic give_verdict;
		begin
			$display("mismatches %0d of %0d checks", error_cnt, tests_run);
			if (error_cnt == 0 && tests_run > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask : give_verdict
	task automatic run(input otpc_op_type op, input logic [12:0] a, input logic [7:0] wd,
		input otpc_res_type res, input logic [4:0] x, input logic [7:0] rd);
		int n;
		begin
			n = 0;
			@(negedge ref_clk);
			while (cmd_ready !== 1'b1 && n < 100)
			begin
				@(negedge ref_clk);
				n++;
			end
			if (n >= 100)
			begin
				error_cnt++;
				give_verdict();
			end
			exp_q.push_back({op == otpc_op_program, res, x, rd});
			cmd_op = op;
			cmd_addr = a;
			cmd_wdata = wd;
			cmd_valid = 1'b1;
			@(negedge ref_clk);
			cmd_valid = 1'b0;
			while (rsp_valid !== 1'b1 && n < 20000)
			begin
				@(negedge ref_clk);
				n++;
			end
			if (n >= 20000)
			begin
				error_cnt++;
				give_verdict();
			end
		end
	endtask : run
	// response checker takes the oldest expectation
	always @(negedge ref_clk)
		if (rsp_valid === 1'b1)
		begin
			e = exp_q.pop_front();
			`CHK({e[15], result, pulses, rdata}, e)
		end
	initial
	begin
		repeat (20) @(negedge ref_clk);
		rstn = 1'b1;
		run(otpc_op_read, 13'h1FFF, 8'h00, otpc_res_ok, 5'h00, 8'hFF);
		run(otpc_op_signature, 13'h0000, 8'h00, otpc_res_ok, 5'h00, 8'h5A);
		run(otpc_op_signature, 13'h0001, 8'h00, otpc_res_ok, 5'h00, 8'hC3);
		for (int i = 1; i < 7; i++)
		begin
			d = 8'($random(seed));
			run(otpc_op_program, 13'(i * 291), d, otpc_res_ok, (d == 8'hFF) ? 5'd1 : 5'd2, d);
			run(otpc_op_read, 13'(i * 291), 8'h00, otpc_res_ok, 5'h00, d);
			run(otpc_op_verify_cold, 13'(i * 291), d, otpc_res_ok, 5'h00, d);
			run(otpc_op_verify_cold, 13'(i * 291), ~d, otpc_res_verify_fail, 5'h00, d);
		end
		run(otpc_op_program, 13'h1ABC, 8'h00, otpc_res_program_fail, 5'd25, 8'hFF);
		run(otpc_op_read, 13'h1ABC, 8'h00, otpc_res_ok, 5'h00, 8'hFF);
		@(negedge ref_clk);
		cmd_op = otpc_op_standby;
		cmd_valid = 1'b1;
		repeat (10)
		begin
			@(negedge ref_clk);
			`CHK(sel_n, 1'b1)
		end
		cmd_valid = 1'b0;
		`CHK(exp_q.size(), 0)
		give_verdict();
	end
endmodule : tb_top
